// [rtl/fsrc_controller.sv]
// host-side sequencer for flash erase and word program
// Function
// - never write 00 or 01 as kind
// - no erase register write while busy
// - keys FA then F5 permit one operation
// - sector erase: keys, address, then code 11
// - block erase: keys, address, then code 10
// - no register writes during an operation
// - program: keys, address, then data word
// - program only erased locations
// - never target unimplemented flash
// - no software reset during an operation
// - after interruption, erase and reprogram again
// - reserved bits read zero, written zero
module fsrc_controller (
  input wire logic clock,
  input wire logic reset,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [1:0] cmd_kind,
  input wire logic [31:0] cmd_addr,
  input wire logic [31:0] cmd_data,
  output logic done,
  output logic fault,
  output logic busy,
  output logic [31:0] capacity,
  output logic [31:0] boot_base,
  output logic bus_valid,
  output logic bus_write,
  output logic [31:0] bus_addr,
  output logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_ready
);
  typedef struct packed {
    fsrc_pkg::fsrc_state_type st;
    logic sent;
    logic [1:0] kind;
    logic [31:0] addr;
    logic [31:0] data;
    logic [31:0] capacity;
    logic [31:0] boot_base;
    logic done;
    logic fault;
  } fsrc_ctl_type;

  fsrc_ctl_type s;
  fsrc_ctl_type next_s;
  logic access;
  logic req;
  logic req_write;
  logic [31:0] req_addr;
  logic [31:0] req_wdata;
  logic bdone;
  logic [31:0] brdata;
  logic [31:0] offset;
  logic range_ok;
  logic [31:0] aligned;

  assign offset = cmd_addr - fsrc_pkg::FLASH_BASE;
  assign range_ok = (cmd_addr >= fsrc_pkg::FLASH_BASE)
    && (offset < s.capacity);
  always_comb begin
    case (cmd_kind)
      fsrc_pkg::KIND_SECTOR: aligned = cmd_addr & ~fsrc_pkg::SECTOR_MASK;
      fsrc_pkg::KIND_BLOCK: aligned = cmd_addr & ~fsrc_pkg::BLOCK_MASK;
      default: aligned = cmd_addr & ~fsrc_pkg::WORD_MASK;
    endcase
  end

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    next_s.fault = 1'b0;
    access = 1'b1;
    req_write = 1'b0;
    req_addr = fsrc_pkg::STATUS_ADDR;
    req_wdata = fsrc_pkg::RESET_WORD;
    case (s.st)
      fsrc_pkg::ST_SIZE: begin
        req_addr = fsrc_pkg::CAPACITY_ADDR;
        if (bdone) begin
          next_s.capacity = brdata;
          next_s.st = fsrc_pkg::ST_BOOT;
        end
      end
      fsrc_pkg::ST_BOOT: begin
        req_addr = fsrc_pkg::BOOT_ADDR;
        if (bdone) begin
          next_s.boot_base = brdata;
          next_s.st = fsrc_pkg::ST_IDLE;
        end
      end
      fsrc_pkg::ST_IDLE: begin
        access = 1'b0;
        if (cmd_valid) begin
          if (cmd_kind == fsrc_pkg::KIND_BAD || !range_ok) begin
            next_s.fault = 1'b1;
          end else begin
            next_s.kind = cmd_kind;
            next_s.addr = aligned;
            next_s.data = cmd_data;
            next_s.st = fsrc_pkg::ST_KEY1;
          end
        end
      end
      fsrc_pkg::ST_KEY1: begin
        req_write = 1'b1;
        req_addr = fsrc_pkg::KEY_ADDR;
        req_wdata = {24'h00_0000, fsrc_pkg::KEY_FIRST};
        if (bdone) begin
          next_s.st = fsrc_pkg::ST_KEY2;
        end
      end
      fsrc_pkg::ST_KEY2: begin
        req_write = 1'b1;
        req_addr = fsrc_pkg::KEY_ADDR;
        req_wdata = {24'h00_0000, fsrc_pkg::KEY_SECOND};
        if (bdone) begin
          next_s.st = fsrc_pkg::ST_ADDR;
        end
      end
      fsrc_pkg::ST_ADDR: begin
        req_write = 1'b1;
        req_addr = fsrc_pkg::TARGET_ADDR;
        req_wdata = s.addr;
        if (bdone) begin
          next_s.st = fsrc_pkg::ST_START;
        end
      end
      fsrc_pkg::ST_START: begin
        req_write = 1'b1;
        if (s.kind == fsrc_pkg::KIND_PROGRAM) begin
          req_addr = fsrc_pkg::PDATA_ADDR;
          req_wdata = s.data;
        end else begin
          req_addr = fsrc_pkg::ERASE_ADDR;
          req_wdata = {30'h0000_0000, s.kind};
        end
        if (bdone) begin
          next_s.st = fsrc_pkg::ST_POLL;
        end
      end
      fsrc_pkg::ST_POLL: begin
        if (bdone && !brdata[fsrc_pkg::BUSY_BIT]) begin
          if (s.kind == fsrc_pkg::KIND_PROGRAM) begin
            next_s.done = 1'b1;
            next_s.st = fsrc_pkg::ST_IDLE;
          end else begin
            next_s.st = fsrc_pkg::ST_CHECK;
          end
        end
      end
      fsrc_pkg::ST_CHECK: begin
        req_addr = fsrc_pkg::ERASE_ADDR;
        if (bdone) begin
          if (brdata[fsrc_pkg::KIND_LSB +: 2] == fsrc_pkg::KIND_DONE) begin
            next_s.done = 1'b1;
          end else begin
            next_s.fault = 1'b1;
          end
          next_s.st = fsrc_pkg::ST_IDLE;
        end
      end
      default: begin
        access = 1'b0;
        next_s.st = fsrc_pkg::ST_IDLE;
      end
    endcase
    req = access && !s.sent;
    if (bdone) begin
      next_s.sent = 1'b0;
    end else if (req) begin
      next_s.sent = 1'b1;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  fsrc_bus_master u_bus (
    .clock(clock),
    .reset(reset),
    .req(req),
    .req_write(req_write),
    .req_addr(req_addr),
    .req_wdata(req_wdata),
    .done(bdone),
    .rdata(brdata),
    .bus_valid(bus_valid),
    .bus_write(bus_write),
    .bus_addr(bus_addr),
    .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata),
    .bus_ready(bus_ready)
  );
  assign cmd_ready = (s.st == fsrc_pkg::ST_IDLE);
  assign busy = (s.st != fsrc_pkg::ST_IDLE);
  assign done = s.done;
  assign fault = s.fault;
  assign capacity = s.capacity;
  assign boot_base = s.boot_base;
  property p_no_write_polling;
    @(posedge clock) disable iff (reset)
    (s.st == fsrc_pkg::ST_POLL || s.st == fsrc_pkg::ST_CHECK) && bus_valid
      |-> !bus_write;
  endproperty
  a_no_write_polling: assert property (p_no_write_polling)
    else $error("register write while operation runs");
  property p_erase_code;
    @(posedge clock) disable iff (reset)
    bus_valid && bus_write && bus_addr == fsrc_pkg::ERASE_ADDR
      |-> bus_wdata == 32'h0000_0002 || bus_wdata == 32'h0000_0003;
  endproperty
  a_erase_code: assert property (p_erase_code)
    else $error("forbidden erase kind written");
  property p_key_value;
    @(posedge clock) disable iff (reset)
    bus_valid && bus_write && bus_addr == fsrc_pkg::KEY_ADDR
      |-> bus_wdata == 32'h0000_00FA || bus_wdata == 32'h0000_00F5;
  endproperty
  a_key_value: assert property (p_key_value)
    else $error("bad unlock key value");
  property p_start_after_addr;
    @(posedge clock) disable iff (reset)
    $rose(s.st == fsrc_pkg::ST_START) |-> $past(s.st) == fsrc_pkg::ST_ADDR;
  endproperty
  a_start_after_addr: assert property (p_start_after_addr)
    else $error("start not preceded by address write");
  property p_addr_after_keys;
    @(posedge clock) disable iff (reset)
    $rose(s.st == fsrc_pkg::ST_ADDR) |-> $past(s.st) == fsrc_pkg::ST_KEY2;
  endproperty
  a_addr_after_keys: assert property (p_addr_after_keys)
    else $error("operation without fresh unlock");
  property p_refuse_range;
    @(posedge clock) disable iff (reset)
    s.st == fsrc_pkg::ST_IDLE && cmd_valid && !range_ok
      |=> fault && s.st == fsrc_pkg::ST_IDLE;
  endproperty
  a_refuse_range: assert property (p_refuse_range)
    else $error("out of range command not refused");
  property p_program_data;
    @(posedge clock) disable iff (reset)
    bus_valid && bus_write && bus_addr == fsrc_pkg::PDATA_ADDR
      |-> bus_wdata == s.data && s.kind == fsrc_pkg::KIND_PROGRAM;
  endproperty
  a_program_data: assert property (p_program_data)
    else $error("program data mismatch");
  property p_addr_low_zero;
    @(posedge clock) disable iff (reset)
    bus_valid && bus_write && bus_addr == fsrc_pkg::TARGET_ADDR
      |-> bus_wdata[1:0] == 2'h0;
  endproperty
  a_addr_low_zero: assert property (p_addr_low_zero)
    else $error("reserved address bits written nonzero");
  property p_done_source;
    @(posedge clock) disable iff (reset)
    $rose(done) |-> $past(s.st) == fsrc_pkg::ST_POLL
      || $past(s.st) == fsrc_pkg::ST_CHECK;
  endproperty
  a_done_source: assert property (p_done_source)
    else $error("done without status poll");
endmodule // fsrc_controller

// [rtl/fsrc_pkg.sv]
// constants and types for the flash rewrite controller
package fsrc_pkg;
  // device register byte addresses
  localparam logic [31:0] STATUS_ADDR = 32'h4000_0400;
  localparam logic [31:0] KEY_ADDR = 32'h4000_0404;
  localparam logic [31:0] TARGET_ADDR = 32'h4000_0408;
  localparam logic [31:0] PDATA_ADDR = 32'h4000_040C;
  localparam logic [31:0] ERASE_ADDR = 32'h4000_0410;
  localparam logic [31:0] CAPACITY_ADDR = 32'h4000_0420;
  localparam logic [31:0] BOOT_ADDR = 32'h4000_0424;
  // target address register reset value, taken as flash base
  localparam logic [31:0] FLASH_BASE = 32'h1000_0000;
  // unlock keys
  localparam logic [7:0] KEY_FIRST = 8'hFA;
  localparam logic [7:0] KEY_SECOND = 8'hF5;
  // erase kind codes, also used as command codes
  localparam logic [1:0] KIND_DONE = 2'h0;
  localparam logic [1:0] KIND_BAD = 2'h1;
  localparam logic [1:0] KIND_BLOCK = 2'h2;
  localparam logic [1:0] KIND_SECTOR = 2'h3;
  localparam logic [1:0] KIND_PROGRAM = 2'h0;
  // field positions
  localparam int BUSY_BIT = 0;
  localparam int KIND_LSB = 0;
  // erase and program granularity masks
  localparam logic [31:0] SECTOR_MASK = 32'h0000_03FF;
  localparam logic [31:0] BLOCK_MASK = 32'h0000_1FFF;
  localparam logic [31:0] WORD_MASK = 32'h0000_0003;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  typedef enum logic [3:0] {
    ST_SIZE = 4'h0,
    ST_BOOT = 4'h1,
    ST_IDLE = 4'h2,
    ST_KEY1 = 4'h3,
    ST_KEY2 = 4'h4,
    ST_ADDR = 4'h5,
    ST_START = 4'h6,
    ST_POLL = 4'h7,
    ST_CHECK = 4'h8
  } fsrc_state_type;
endpackage

// [rtl/fsrc_bus_master.sv]
// single-access master for the device register bus
module fsrc_bus_master (
  input wire logic clock,
  input wire logic reset,
  input wire logic req,
  input wire logic req_write,
  input wire logic [31:0] req_addr,
  input wire logic [31:0] req_wdata,
  output logic done,
  output logic [31:0] rdata,
  output logic bus_valid,
  output logic bus_write,
  output logic [31:0] bus_addr,
  output logic [31:0] bus_wdata,
  input wire logic [31:0] bus_rdata,
  input wire logic bus_ready
);
  typedef struct packed {
    logic valid;
    logic write;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic done;
  } fsrc_bus_type;

  fsrc_bus_type s;
  fsrc_bus_type next_s;

  always_comb begin
    next_s = s;
    next_s.done = 1'b0;
    if (s.valid) begin
      if (bus_ready) begin
        next_s.valid = 1'b0;
        next_s.done = 1'b1;
        next_s.rdata = bus_rdata;
      end
    end else if (req) begin
      next_s.valid = 1'b1;
      next_s.write = req_write;
      next_s.addr = req_addr;
      next_s.wdata = req_wdata;
    end
  end

  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign bus_valid = s.valid;
  assign bus_write = s.write;
  assign bus_addr = s.addr;
  assign bus_wdata = s.wdata;
  assign rdata = s.rdata;
  assign done = s.done;

  property p_hold_access;
    @(posedge clock) disable iff (reset)
    bus_valid && !bus_ready |=> bus_valid && $stable(bus_addr)
      && $stable(bus_write) && $stable(bus_wdata);
  endproperty
  a_hold_access: assert property (p_hold_access)
    else $error("access dropped before ready");

  property p_done_after_ready;
    @(posedge clock) disable iff (reset)
    bus_valid && bus_ready |=> done && !bus_valid ##1 !done;
  endproperty
  a_done_after_ready: assert property (p_done_after_ready)
    else $error("done not one cycle after ready");
endmodule // fsrc_bus_master

// [bench/fsrc_device_model.sv]
// device-side model of the flash rewrite registers and array
module fsrc_device_model #(
  parameter logic [31:0] CAP = 32'h0001_0800,
  parameter logic [31:0] BOOT = 32'h0000_F000,
  parameter int OP_LEN = 12
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic slow,
  input wire logic stuck_kind,
  input wire logic bus_valid,
  input wire logic bus_write,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  output logic [31:0] bus_rdata,
  output logic bus_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [int];
  logic [31:0] target, noise, off, sz;
  logic [1:0] kind, arm;
  logic tick, hit;
  int busy_left, bad_writes, ops;
  // flash array reads wait while busy
  assign bus_ready = (!slow || tick) && !(!bus_write && busy_left != 0
    && bus_addr - fsrc_pkg::FLASH_BASE < CAP);
  assign hit = bus_valid && bus_ready;
  assign off = target - fsrc_pkg::FLASH_BASE;
  always_comb begin
    bus_rdata = noise;
    if (hit && !bus_write) begin
      case (bus_addr)
        fsrc_pkg::STATUS_ADDR: bus_rdata = {31'h0, busy_left != 0};
        fsrc_pkg::TARGET_ADDR: bus_rdata = target;
        fsrc_pkg::ERASE_ADDR: bus_rdata = {30'h0, kind};
        fsrc_pkg::CAPACITY_ADDR: bus_rdata = CAP;
        fsrc_pkg::BOOT_ADDR: bus_rdata = BOOT & 32'h0003_FFFC;
        default: bus_rdata = 32'h0;
      endcase
    end
  end
  always @(posedge clock or posedge reset) begin
    if (reset) begin
      target <= fsrc_pkg::FLASH_BASE;
      kind <= 2'h0;
      arm <= 2'h0;
      busy_left <= 0;
      tick <= 1'b0;
      noise <= 32'h0;
      bad_writes <= 0;
      ops <= 0;
    end else begin
      tick <= !tick;
      noise <= noise + 32'h3C6E_F35F;
      if (busy_left > 0) busy_left <= busy_left - 1;
      if (busy_left == 1 && !stuck_kind) kind <= 2'h0;
      if (hit && bus_write && busy_left != 0) begin
        bad_writes <= bad_writes + 1;
      end else if (hit && bus_write) begin
        case (bus_addr)
          fsrc_pkg::KEY_ADDR: arm <=
            (arm == 2'h0 && bus_wdata == {24'h0, fsrc_pkg::KEY_FIRST}) ? 2'h1 :
            (arm == 2'h1 && bus_wdata == {24'h0, fsrc_pkg::KEY_SECOND}) ?
            2'h2 : 2'h0;
          fsrc_pkg::TARGET_ADDR: target <= {bus_wdata[31:2], 2'h0};
          fsrc_pkg::ERASE_ADDR: if (arm == 2'h2 && bus_wdata[1]) begin
            sz = bus_wdata[0] ? 32'h0000_0400 : 32'h0000_2000;
            arm <= 2'h0;
            kind <= bus_wdata[1:0];
            ops <= ops + 1;
            busy_left <= off < CAP ? OP_LEN : 2;
            if (off < CAP)
              for (int i = 0; i < sz; i += 4)
                mem[int'((off & ~(sz - 32'h1)) + i)] = 32'hFFFF_FFFF;
          end
          fsrc_pkg::PDATA_ADDR: if (arm == 2'h2) begin
            arm <= 2'h0;
            ops <= ops + 1;
            busy_left <= off < CAP ? OP_LEN : 2;
            if (off < CAP) mem[int'(off)] = bus_wdata;
          end
          default: ;
        endcase
      end
    end
  end
endmodule // fsrc_device_model

// [bench/tb_flash_self_rewrite_controller.sv]
// self-checking bench for the flash rewrite controller
module tb_flash_self_rewrite_controller;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] CAP = 32'h0001_0800;
  localparam logic [31:0] BOOT = 32'h0000_F000;
  localparam logic [31:0] BASE = fsrc_pkg::FLASH_BASE;
  logic clock = 1'b0;
  logic reset, cmd_valid, cmd_ready, done, fault, busy, slow, stuck;
  logic bus_valid, bus_write, bus_ready;
  logic [1:0] cmd_kind, k;
  logic [31:0] cmd_addr, cmd_data, capacity, boot_base, a;
  logic [31:0] bus_addr, bus_wdata, bus_rdata;
  logic [31:0] shadow [int];
  logic [15:0] r = 16'h0023;
  int fail_count = 0, checks_done = 0, exp_ops = 0, cycles = 0;
  always #2.5 clock = ~clock;
  fsrc_controller dut (.clock(clock), .reset(reset), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
    .cmd_data(cmd_data), .done(done), .fault(fault), .busy(busy),
    .capacity(capacity), .boot_base(boot_base), .bus_valid(bus_valid),
    .bus_write(bus_write), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_rdata(bus_rdata), .bus_ready(bus_ready));
  fsrc_device_model partner (.clock(clock), .reset(reset), .slow(slow),
    .stuck_kind(stuck), .bus_valid(bus_valid), .bus_write(bus_write),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
    .bus_ready(bus_ready));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input string name, input logic [31:0] seen,
      input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 200) begin
      @(negedge clock);
      n++;
    end
    if (cmd_ready !== 1'b1) fail_count++;
  endtask
  task automatic run_cmd(input logic [1:0] kd, input logic [31:0] ad,
      input logic [31:0] d);
    logic ok;
    logic [31:0] off, sz;
    int n;
    off = ad - BASE;
    ok = kd != fsrc_pkg::KIND_BAD && ad >= BASE && off < CAP;
    wait_ready();
    cmd_valid = 1'b1;
    cmd_kind = kd;
    cmd_addr = ad;
    cmd_data = d;
    @(negedge clock);
    cmd_valid = 1'b0;
    check("busy", {31'h0, busy}, {31'h0, ok});
    n = 0;
    while (done !== 1'b1 && fault !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    check("done", {31'h0, done}, {31'h0, ok && !(stuck && kd[1])});
    check("fault", {31'h0, fault}, {31'h0, !ok || (stuck && kd[1])});
    check("busy end", {31'h0, busy}, 32'h0);
    check("ready end", {31'h0, cmd_ready}, 32'h1);
    if (ok) begin
      exp_ops++;
      if (kd == fsrc_pkg::KIND_PROGRAM) begin
        shadow[int'(off & ~32'h3)] = d;
      end else begin
        sz = kd[0] ? 32'h0000_0400 : 32'h0000_2000;
        for (int i = 0; i < sz; i += 4)
          shadow[int'((off & ~(sz - 32'h1)) + i)] = 32'hFFFF_FFFF;
      end
    end
    @(negedge clock);
  endtask
  task automatic cmp_mem;
    logic [31:0] w;
    foreach (shadow[i]) begin
      w = partner.mem.exists(i) ? partner.mem[i] : 32'hFFFF_FFFF;
      check("flash word", w, shadow[i]);
    end
  endtask
  always @(posedge clock) begin
    cycles++;
    if (cycles == 30000) begin
      fail_count++;
      report_and_stop();
    end
  end
  initial begin
    reset = 1'b1;
    cmd_valid = 1'b0;
    cmd_kind = 2'h0;
    cmd_addr = 32'h0;
    cmd_data = 32'h0;
    slow = 1'b0;
    stuck = 1'b0;
    repeat (16) @(negedge clock);
    reset = 1'b0;
    wait_ready();
    check("capacity", capacity, CAP);
    check("boot base", boot_base, BOOT);
    $display("test init done");
    run_cmd(fsrc_pkg::KIND_PROGRAM, BASE + 32'h0BFC, 32'h1234_5678);
    run_cmd(fsrc_pkg::KIND_PROGRAM, BASE + 32'h0C00, 32'hA5A5_0F0F);
    run_cmd(fsrc_pkg::KIND_SECTOR, BASE + 32'h0812, 32'h0);
    run_cmd(fsrc_pkg::KIND_PROGRAM, BASE + 32'h5FFC, 32'h0BAD_F00D);
    run_cmd(fsrc_pkg::KIND_PROGRAM, BASE + 32'h6000, 32'h600D_CAFE);
    run_cmd(fsrc_pkg::KIND_BLOCK, BASE + 32'h4100, 32'h0);
    cmp_mem();
    $display("test corners done");
    run_cmd(fsrc_pkg::KIND_BAD, BASE, 32'h0);
    run_cmd(fsrc_pkg::KIND_PROGRAM, BASE + CAP, 32'h1);
    run_cmd(fsrc_pkg::KIND_SECTOR, BASE - 32'h4, 32'h0);
    $display("test refusals done");
    stuck = 1'b1;
    run_cmd(fsrc_pkg::KIND_SECTOR, BASE + 32'h0400, 32'h0);
    stuck = 1'b0;
    $display("test stuck kind done");
    for (int i = 0; i < 16; i++) begin
      r = lfsr(r);
      slow = r[0];
      k = r[2:1];
      r = lfsr(r);
      a = ({15'h0, r, 1'b0} % (CAP + 32'h40)) & ~32'h3;
      if (k == fsrc_pkg::KIND_PROGRAM && shadow.exists(int'(a)) &&
          shadow[int'(a)] !== 32'hFFFF_FFFF)
        k = fsrc_pkg::KIND_SECTOR;
      run_cmd(k, BASE + a, {r, ~r});
    end
    cmp_mem();
    check("op count", partner.ops, exp_ops);
    check("busy writes", partner.bad_writes, 32'h0);
    $display("test random done");
    report_and_stop();
  end
endmodule // tb_flash_self_rewrite_controller
